// ==== design/bscan_pkg.sv ====
package bscan_pkg;

    // Widths and counts
    localparam int IR_W = 8;
    localparam int SEL_W = 3;
    localparam int CELLS = 18;
    localparam int CHAIN_W = 2 * CELLS;
    localparam int SYNC_W = 8;

    // Signature feedback tap, x^18 + x^11 + 1
    localparam int SIG_TAP = 10;

    // Instruction codes
    localparam logic [7:0] IR_CAPTURE = 8'h81;
    localparam logic [7:0] OP_BYPASS = 8'hFF;
    localparam logic [7:0] OP_CHAIN_SCAN = 8'h02;
    localparam logic [7:0] OP_RUN_TEST = 8'h09;
    localparam logic [7:0] OP_SELECTOR_SCAN = 8'h0E;

    // Test operation selector
    localparam logic [2:0] SEL_SIG_COUNT = 3'h7;
    localparam logic [2:0] SEL_RESET = 3'h0;

    // Data register selection
    localparam logic [1:0] DR_BYPASS = 2'h0;
    localparam logic [1:0] DR_CHAIN = 2'h1;
    localparam logic [1:0] DR_SELECTOR = 2'h2;

    // Positions inside the synchronised pin vector
    localparam int PIN_TCK = 0;
    localparam int PIN_TMS = 1;
    localparam int PIN_TDI = 2;
    localparam int PIN_L1A = 3;
    localparam int PIN_L1B = 4;
    localparam int PIN_L2A = 5;
    localparam int PIN_L2B = 6;
    localparam int PIN_SPARE = 7;

    typedef enum logic [3:0] {
        TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
        UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } tap_state_t;

endpackage

// ==== design/pin_edge_sync.sv ====
`timescale 1ns/10ps
module pin_edge_sync #(
    parameter int W = 8,
    parameter int CLK_BIT = 0
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o,
    output logic rise_o,
    output logic fall_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic clk_last_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_nxt;
    logic clk_last_nxt;

    ////////////////////////////////////////////////////////////////
    // Two-stage capture, then edge detect on the second stage
    always_comb begin
        meta_nxt = pin_i;
        sync_nxt = meta_r;
        clk_last_nxt = sync_r[CLK_BIT];
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            meta_r <= '0;
            sync_r <= '0;
            clk_last_r <= 1'b0;
        end else if (ce_i) begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            clk_last_r <= clk_last_nxt;
        end
    end

    assign sync_o = sync_r;
    assign rise_o = sync_r[CLK_BIT] & ~clk_last_r;
    assign fall_o = ~sync_r[CLK_BIT] & clk_last_r;
endmodule

// ==== design/boundary_scan_signature_count.sv ====
// What this block does
// - In signature-count mode, input cells compact pin data into 18-bit signature per rise.
// - Output cells concurrently form an 18-bit binary up-count each rising test-clock edge.
// - Each falling edge copies the count into holding latches driven onto output pins.
// - All test state changes only on a test-clock edge.
// - Test data in, mode select and function inputs are sampled on rising edges.
// - Test data out and function outputs change only on falling edges.
// - Instruction register is 8 bits and captures 10000001 leaving Capture-IR.
// - Entering a shift state enables the data-out driver on the falling edge.
// - One bit shifts per rising edge in shift states, last one leaving to Exit1.
// - The falling edge in Exit1-IR or Exit1-DR releases the data-out driver.
// - The shifted instruction moves into the active latch on the Update-IR falling edge.
// - Instruction 11111111 decodes as bypass.
// - Bypass register loads 0 on the rising edge leaving Capture-DR.
// - Selected data register updates on the Update-DR falling edge.
// - Signature-count mode is selected when selector bits 2 to 0 hold 111.
// - The operation runs only with run-test instruction active in Run-Test/Idle.
// - Unless both lanes share one flow direction, the test operation is not run.
`timescale 1ns/10ps
module boundary_scan_signature_count (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic lane1_a_output_enable_i,
    input wire logic lane1_b_output_enable_i,
    input wire logic lane2_a_output_enable_i,
    input wire logic lane2_b_output_enable_i,
    input wire logic [17:0] data_in_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic [17:0] data_out_o
);
    localparam int N = bscan_pkg::CELLS;

    logic [bscan_pkg::SYNC_W-1:0] pins_s;
    logic [N-1:0] din_meta_r;
    logic [N-1:0] din_s_r;
    logic tck_rise;
    logic tck_fall;
    logic adv;
    logic fal;
    logic lanes_ok;
    logic run_ok;

    bscan_pkg::tap_state_t state_r, state_nxt;
    logic [7:0] ir_sh_r, ir_sh_nxt;
    logic [7:0] ir_r, ir_nxt;
    logic bypass_r, bypass_nxt;
    logic [2:0] sel_sh_r, sel_sh_nxt;
    logic [2:0] sel_r, sel_nxt;
    logic [bscan_pkg::CHAIN_W-1:0] chain_r, chain_nxt;
    logic [N-1:0] latch_r, latch_nxt;
    logic tdo_r, tdo_nxt;
    logic tdo_oe_r, tdo_oe_nxt;

    ////////////////////////////////////////////////////////////////
    // Helpers
    function automatic bscan_pkg::tap_state_t tap_next(bscan_pkg::tap_state_t s, logic tms);
        case (s)
            bscan_pkg::TEST_RESET: tap_next = tms ? bscan_pkg::TEST_RESET : bscan_pkg::RUN_IDLE;
            bscan_pkg::RUN_IDLE: tap_next = tms ? bscan_pkg::SEL_DR : bscan_pkg::RUN_IDLE;
            bscan_pkg::SEL_DR: tap_next = tms ? bscan_pkg::SEL_IR : bscan_pkg::CAP_DR;
            bscan_pkg::CAP_DR: tap_next = tms ? bscan_pkg::EXIT1_DR : bscan_pkg::SHIFT_DR;
            bscan_pkg::SHIFT_DR: tap_next = tms ? bscan_pkg::EXIT1_DR : bscan_pkg::SHIFT_DR;
            bscan_pkg::EXIT1_DR: tap_next = tms ? bscan_pkg::UPD_DR : bscan_pkg::PAUSE_DR;
            bscan_pkg::PAUSE_DR: tap_next = tms ? bscan_pkg::EXIT2_DR : bscan_pkg::PAUSE_DR;
            bscan_pkg::EXIT2_DR: tap_next = tms ? bscan_pkg::UPD_DR : bscan_pkg::SHIFT_DR;
            bscan_pkg::UPD_DR: tap_next = tms ? bscan_pkg::SEL_DR : bscan_pkg::RUN_IDLE;
            bscan_pkg::SEL_IR: tap_next = tms ? bscan_pkg::TEST_RESET : bscan_pkg::CAP_IR;
            bscan_pkg::CAP_IR: tap_next = tms ? bscan_pkg::EXIT1_IR : bscan_pkg::SHIFT_IR;
            bscan_pkg::SHIFT_IR: tap_next = tms ? bscan_pkg::EXIT1_IR : bscan_pkg::SHIFT_IR;
            bscan_pkg::EXIT1_IR: tap_next = tms ? bscan_pkg::UPD_IR : bscan_pkg::PAUSE_IR;
            bscan_pkg::PAUSE_IR: tap_next = tms ? bscan_pkg::EXIT2_IR : bscan_pkg::PAUSE_IR;
            bscan_pkg::EXIT2_IR: tap_next = tms ? bscan_pkg::UPD_IR : bscan_pkg::SHIFT_IR;
            bscan_pkg::UPD_IR: tap_next = tms ? bscan_pkg::SEL_DR : bscan_pkg::RUN_IDLE;
            default: tap_next = bscan_pkg::TEST_RESET;
        endcase
    endfunction

    function automatic logic [1:0] dr_select(logic [7:0] ir);
        case (ir)
            bscan_pkg::OP_CHAIN_SCAN: dr_select = bscan_pkg::DR_CHAIN;
            bscan_pkg::OP_SELECTOR_SCAN: dr_select = bscan_pkg::DR_SELECTOR;
            default: dr_select = bscan_pkg::DR_BYPASS;
        endcase
    endfunction

    function automatic logic [N-1:0] sig_step(logic [N-1:0] s, logic [N-1:0] d);
        sig_step = {s[N-2:0], s[N-1] ^ s[bscan_pkg::SIG_TAP]} ^ d;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Pin capture
    // sampled pins
    pin_edge_sync #(.W(bscan_pkg::SYNC_W), .CLK_BIT(bscan_pkg::PIN_TCK)) u_sync (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .pin_i({1'b0, lane2_b_output_enable_i, lane2_a_output_enable_i,
            lane1_b_output_enable_i, lane1_a_output_enable_i, tdi_i, tms_i, tck_i}),
        .sync_o(pins_s),
        .rise_o(tck_rise),
        .fall_o(tck_fall)
    );

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            din_meta_r <= '0;
            din_s_r <= '0;
        end else if (ce_i) begin
            din_meta_r <= data_in_i;
            din_s_r <= din_meta_r;
        end
    end

    assign adv = ce_i & tck_rise;
    assign fal = ce_i & tck_fall;
    assign lanes_ok = (pins_s[bscan_pkg::PIN_L1A] != pins_s[bscan_pkg::PIN_L1B])
        && (pins_s[bscan_pkg::PIN_L2A] != pins_s[bscan_pkg::PIN_L2B])
        && (pins_s[bscan_pkg::PIN_L1A] == pins_s[bscan_pkg::PIN_L2A]);
    assign run_ok = (state_r == bscan_pkg::RUN_IDLE) && (ir_r == bscan_pkg::OP_RUN_TEST)
        && (sel_r == bscan_pkg::SEL_SIG_COUNT) && lanes_ok;

    ////////////////////////////////////////////////////////////////
    // Controller and instruction
    always_comb begin
        state_nxt = state_r;
        ir_sh_nxt = ir_sh_r;
        ir_nxt = ir_r;
        if (adv) begin
            state_nxt = tap_next(state_r, pins_s[bscan_pkg::PIN_TMS]);
            if (state_r == bscan_pkg::CAP_IR)
                ir_sh_nxt = bscan_pkg::IR_CAPTURE;
            else if (state_r == bscan_pkg::SHIFT_IR)
                ir_sh_nxt = {pins_s[bscan_pkg::PIN_TDI], ir_sh_r[7:1]};
        end
        if (fal) begin
            if (state_r == bscan_pkg::UPD_IR)
                ir_nxt = ir_sh_r;
            else if (state_r == bscan_pkg::TEST_RESET)
                ir_nxt = bscan_pkg::OP_BYPASS;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            state_r <= bscan_pkg::TEST_RESET;
            ir_sh_r <= bscan_pkg::IR_CAPTURE;
            ir_r <= bscan_pkg::OP_BYPASS;
        end else begin
            state_r <= state_nxt;
            ir_sh_r <= ir_sh_nxt;
            ir_r <= ir_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Data registers, cells and pins
    always_comb begin
        bypass_nxt = bypass_r;
        sel_sh_nxt = sel_sh_r;
        sel_nxt = sel_r;
        chain_nxt = chain_r;
        latch_nxt = latch_r;
        tdo_nxt = tdo_r;
        tdo_oe_nxt = tdo_oe_r;
        if (adv) begin
            case (state_r)
                bscan_pkg::CAP_DR: begin
                    if (dr_select(ir_r) == bscan_pkg::DR_BYPASS)
                        bypass_nxt = 1'b0;
                    else if (dr_select(ir_r) == bscan_pkg::DR_CHAIN)
                        chain_nxt[2*N-1:N] = din_s_r;
                end
                bscan_pkg::SHIFT_DR: begin
                    case (dr_select(ir_r))
                        bscan_pkg::DR_CHAIN:
                            chain_nxt = {pins_s[bscan_pkg::PIN_TDI], chain_r[2*N-1:1]};
                        bscan_pkg::DR_SELECTOR:
                            sel_sh_nxt = {pins_s[bscan_pkg::PIN_TDI], sel_sh_r[2:1]};
                        default: bypass_nxt = pins_s[bscan_pkg::PIN_TDI];
                    endcase
                end
                bscan_pkg::RUN_IDLE: begin
                    if (run_ok) begin
                        chain_nxt[2*N-1:N] = sig_step(chain_r[2*N-1:N], din_s_r);
                        chain_nxt[N-1:0] = chain_r[N-1:0] + 18'h00001;
                    end
                end
                default: begin
                end
            endcase
        end
        if (fal) begin
            tdo_oe_nxt = (state_r == bscan_pkg::SHIFT_IR) || (state_r == bscan_pkg::SHIFT_DR);
            case (state_r)
                bscan_pkg::SHIFT_IR: tdo_nxt = ir_sh_r[0];
                bscan_pkg::SHIFT_DR: begin
                    case (dr_select(ir_r))
                        bscan_pkg::DR_CHAIN: tdo_nxt = chain_r[0];
                        bscan_pkg::DR_SELECTOR: tdo_nxt = sel_sh_r[0];
                        default: tdo_nxt = bypass_r;
                    endcase
                end
                default: tdo_nxt = tdo_r;
            endcase
            if (state_r == bscan_pkg::UPD_DR) begin
                if (dr_select(ir_r) == bscan_pkg::DR_SELECTOR)
                    sel_nxt = sel_sh_r;
                else if (dr_select(ir_r) == bscan_pkg::DR_CHAIN)
                    latch_nxt = chain_r[N-1:0];
            end
            if (run_ok)
                latch_nxt = chain_r[N-1:0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            bypass_r <= 1'b0;
            sel_sh_r <= bscan_pkg::SEL_RESET;
            sel_r <= bscan_pkg::SEL_RESET;
            chain_r <= '0;
            latch_r <= '0;
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            bypass_r <= bypass_nxt;
            sel_sh_r <= sel_sh_nxt;
            sel_r <= sel_nxt;
            chain_r <= chain_nxt;
            latch_r <= latch_nxt;
            tdo_r <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    assign tdo_o = tdo_r;
    assign tdo_oe_o = tdo_oe_r;
    assign data_out_o = latch_r;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    a_ir_capture: assert property (adv && state_r == bscan_pkg::CAP_IR |=>
        ir_sh_r == 8'h81) else $error("IR capture pattern wrong");
    a_ir_shift: assert property (adv && state_r == bscan_pkg::SHIFT_IR |=>
        ir_sh_r == {$past(pins_s[bscan_pkg::PIN_TDI]), $past(ir_sh_r[7:1])})
        else $error("IR shift wrong");
    a_ir_update: assert property (fal && state_r == bscan_pkg::UPD_IR |=>
        ir_r == $past(ir_sh_r)) else $error("IR not updated");
    a_bypass_decode: assert property (adv && state_r == bscan_pkg::SHIFT_DR && ir_r == 8'hFF
        |=> bypass_r == $past(pins_s[bscan_pkg::PIN_TDI])) else $error("All-ones not bypass");
    a_bypass_capture: assert property (adv && state_r == bscan_pkg::CAP_DR
        && dr_select(ir_r) == bscan_pkg::DR_BYPASS |=> !bypass_r)
        else $error("Bypass capture not zero");
    a_tdo_enable: assert property (fal && (state_r == bscan_pkg::SHIFT_IR
        || state_r == bscan_pkg::SHIFT_DR) |=> tdo_oe_o) else $error("Driver not enabled");
    a_tdo_release: assert property (fal && (state_r == bscan_pkg::EXIT1_IR
        || state_r == bscan_pkg::EXIT1_DR) |=> !tdo_oe_o) else $error("Driver not released");
    a_tdo_fall_only: assert property ($changed(tdo_o) || $changed(data_out_o) |->
        $past(fal)) else $error("Output moved off falling edge");
    a_sel_update: assert property (fal && state_r == bscan_pkg::UPD_DR
        && dr_select(ir_r) == bscan_pkg::DR_SELECTOR |=> sel_r == $past(sel_sh_r))
        else $error("Selector not updated");
    a_count_step: assert property (adv && run_ok |=>
        chain_r[N-1:0] == $past(chain_r[N-1:0]) + 18'h00001) else $error("Count step wrong");
    a_sig_step: assert property (adv && run_ok |=>
        chain_r[2*N-1:N] == sig_step($past(chain_r[2*N-1:N]), $past(din_s_r)))
        else $error("Signature step wrong");
    a_count_wrap: assert property (adv && run_ok && chain_r[N-1:0] == 18'h3FFFF |=>
        chain_r[N-1:0] == 18'h00000) else $error("Count did not wrap");
    a_pins_fall: assert property (fal && run_ok |=>
        data_out_o == $past(chain_r[N-1:0])) else $error("Pins not loaded");
    a_run_gated: assert property (adv && state_r == bscan_pkg::RUN_IDLE && !run_ok |=>
        $stable(chain_r)) else $error("Cells moved while not running");
    a_lane_gate: assert property (adv && state_r == bscan_pkg::RUN_IDLE && !lanes_ok |=>
        $stable(chain_r)) else $error("Ran with mixed lanes");
    a_quiet_edges: assert property (!adv && !fal |=>
        $stable(state_r) && $stable(chain_r) && $stable(ir_r)) else $error("State moved idle");

    c_ir_update: cover property (fal && state_r == bscan_pkg::UPD_IR);
    c_dr_shift: cover property (adv && state_r == bscan_pkg::SHIFT_DR);
    c_count_run: cover property (adv && run_ok ##[1:40] fal && run_ok);
endmodule

// ==== bench/tap_ctrl_model.sv ====
`timescale 1ns/10ps
module tap_ctrl_model (
    input wire logic core_clk_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    // Test clock idles low between frames
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode select after fall
    task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (4) @(posedge core_clk_i);
        tck_o <= 1'b1;
        @(posedge core_clk_i);
        // Released line reads inverted
        tdo = tdo_oe_i ? tdo_i : ~tdo_i;
        oe = tdo_oe_i;
        repeat (3) @(posedge core_clk_i);
        tck_o <= 1'b0;
    endtask

    // Five ones reach reset, then idle
    task automatic goto_idle();
        logic t;
        logic e;
        repeat (5) tick(1'b1, 1'b1, t, e);
        tick(1'b0, 1'b0, t, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // last bit with mode select high
    task automatic scan(input logic is_ir, input int n, input logic [35:0] din,
                        output logic [35:0] dout, output logic oe_ok);
        logic t;
        logic e;
        dout = '0;
        oe_ok = 1'b1;
        tick(1'b1, ~din[0], t, e);
        if (is_ir) tick(1'b1, din[1], t, e);
        tick(1'b0, ~din[1], t, e);
        tick(1'b0, din[2], t, e);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], t, e);
            dout[i] = t;
            oe_ok = oe_ok & e;
        end
        tick(1'b1, ~din[0], t, e);
        oe_ok = oe_ok & ~e;
        tick(1'b0, din[3], t, e);
    endtask
endmodule

// ==== bench/boundary_scan_signature_count_tb_top.sv ====
`timescale 1ns/10ps
module boundary_scan_signature_count_tb_top;
    logic core_clk;
    logic nrst;
    logic ce;
    logic [3:0] lanes;
    logic [17:0] data_in;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [17:0] data_out;
    logic [31:0] lfsr_r;
    logic [35:0] din;
    logic [35:0] dout;
    logic ok;
    logic tv;
    logic ev;
    logic [17:0] cnt;
    logic [3:0] lane_tab [4];
    int err_total;
    int comparisons;

    boundary_scan_signature_count u_boundary_scan_signature_count (
        .core_clk_i(core_clk), .nrst_i(nrst), .ce_i(ce), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .lane1_a_output_enable_i(lanes[3]), .lane1_b_output_enable_i(lanes[2]),
        .lane2_a_output_enable_i(lanes[1]), .lane2_b_output_enable_i(lanes[0]),
        .data_in_i(data_in), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .data_out_o(data_out)
    );

    tap_ctrl_model u_tap_ctrl_model (
        .core_clk_i(core_clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe),
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // One zero first, then data one stage late
    function automatic logic [35:0] bypass_exp(input logic [35:0] d, input int n);
        return {d[34:0], 1'b0} & ((36'h1 << n) - 36'h1);
    endfunction

    // Lanes one direction each and the same direction
    function automatic logic lanes_ok(input logic [3:0] l);
        return (l[3] != l[2]) && (l[1] != l[0]) && (l[3] == l[1]);
    endfunction

    function automatic logic [17:0] count_exp(input logic [17:0] c, input logic run);
        return run ? c + 18'h00001 : c;
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Counts: comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic roll();
        lfsr_r = lfsr_step(lfsr_r);
        din = {lfsr_r[7:4], lfsr_r};
    endtask

    task automatic load_ir(input logic [7:0] code);
        u_tap_ctrl_model.scan(1'b1, 8, {28'h0, code}, dout, ok);
        check({28'h0, dout[7:0]}, 36'h081); // captured pattern out
        check({35'h0, ok}, 36'h1); // driver window
    endtask

    task automatic bypass_scan();
        roll();
        u_tap_ctrl_model.scan(1'b0, 6, din, dout, ok);
        check(dout, bypass_exp(din, 6)); // single stage path
        check({35'h0, ok}, 36'h1); // driver window
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge core_clk);
        err_total++;
        end_sim();
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        lanes = 4'h5;
        data_in = 18'h00000;
        lfsr_r = 32'h00000035;
        din = '0;
        err_total = 0;
        comparisons = 0;
        lane_tab = '{4'h5, 4'h6, 4'hF, 4'hA};
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        check({17'h0, tdo_oe, data_out}, 36'h0); // quiet without test clock
        u_tap_ctrl_model.goto_idle();
        load_ir(8'hFF);
        bypass_scan();
        load_ir(8'h0E);
        u_tap_ctrl_model.scan(1'b0, 3, 36'h7, dout, ok); // selector set
        check(dout, 36'h0); // reset selector shifted out
        load_ir(8'h02);
        roll();
        din[17:0] = 18'h3FFFC;
        u_tap_ctrl_model.scan(1'b0, 36, din, dout, ok); // seed loaded
        check(dout, 36'h0); // reset chain shifted out
        check({18'h0, data_out}, {18'h0, din[17:0]}); // update drives latches
        cnt = din[17:0];
        load_ir(8'h09);
        for (int c = 0; c < 4; c++) begin
            lanes <= lane_tab[c];
            repeat (5) begin
                roll();
                data_in <= din[17:0];
                u_tap_ctrl_model.tick(1'b0, din[20], tv, ev);
                repeat (5) @(posedge core_clk);
                cnt = count_exp(cnt, lanes_ok(lanes));
                check({18'h0, data_out}, {18'h0, cnt}); // count on pins
            end
        end
        ce <= 1'b0;
        u_tap_ctrl_model.tick(1'b0, 1'b0, tv, ev);
        repeat (5) @(posedge core_clk);
        check({18'h0, data_out}, {18'h0, cnt}); // frozen while disabled
        ce <= 1'b1;
        u_tap_ctrl_model.tick(1'b0, 1'b0, tv, ev);
        repeat (5) @(posedge core_clk);
        cnt = count_exp(cnt, 1'b1);
        check({18'h0, data_out}, {18'h0, cnt}); // resumes after enable
        cnt = count_exp(cnt, 1'b1);
        load_ir(8'h02);
        din = {data_in, cnt};
        u_tap_ctrl_model.scan(1'b0, 36, din, dout, ok);
        check(dout, din); // captured inputs and count read back
        nrst <= 1'b0;
        repeat (4) @(posedge core_clk);
        check({17'h0, tdo_oe, data_out}, 36'h0); // reset clears pins
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        u_tap_ctrl_model.goto_idle();
        bypass_scan();
        end_sim();
    end
endmodule
